/* core/psf_top.sv */
// processor status flags (low ten bits) with apb access and event interrupt
// How it works
// - interrupt flag set lets maskable requests be accepted; clear blocks them
// - trap flag set raises single-step trap after the next instruction completes
// - taking the single-step trap clears the trap flag
// - sign flag takes the result's top bit
// - zero flag set exactly when the result is zero
// - auxiliary carry flag records carry or borrow across bit 3
// - parity flag set when low result byte has even number of ones
// - carry flag records carry or borrow out of the top result bit
// - reserved bit 1 always reads one, whatever is written
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module psf_top #(
  parameter int unsigned DATA_W = 32
) (
  // clock and reset
  input  wire logic                            MCLK_I,
  input  wire logic                            RST_B_I,
  // apb slave
  input  wire logic                            PSEL_I,
  input  wire logic                            PENABLE_I,
  input  wire logic                            PWRITE_I,
  input  wire logic [psf_pkg::ADDR_W-1:0]      PADDR_I,
  input  wire logic [31:0]                     PWDATA_I,
  input  wire logic [3:0]                      PSTRB_I,
  output logic      [31:0]                     PRDATA_O,
  output logic                                 PREADY_O,
  output logic                                 PSLVERR_O,
  // execution datapath
  input  wire logic                            ALU_VALID_I,
  input  wire logic                            ALU_SUB_I,
  input  wire logic [DATA_W-1:0]               ALU_OP_A_I,
  input  wire logic [DATA_W-1:0]               ALU_OP_B_I,
  output logic      [DATA_W-1:0]               ALU_RESULT_O,
  // instruction boundary and interrupt acceptance
  input  wire logic                            INSN_DONE_I,
  input  wire logic                            MASKABLE_INTERRUPT_REQUEST_I,
  output logic                                 INT_ACCEPT_O,
  output logic                                 STEP_TRAP_O,
  // flag view and event interrupt
  output logic      [31:0]                     FLAGS_O,
  output logic                                 IRQ_O
);

  // flag flip-flops
  logic              if_q;
  logic              trap_q;
  logic              sign_q;
  logic              zero_q;
  logic              aux_q;
  logic              parity_q;
  logic              carry_q;
  // event registers
  logic [1:0]        status_q;
  logic [1:0]        int_en_q;
  logic [1:0]        ev_set;
  logic [1:0]        ev_clr;
  // bus helpers
  logic              setup;
  logic              access;
  logic              wr_flags;
  logic              wr_en;
  logic              wr_clr;
  logic              mapped;
  logic [31:0]       flags_view;
  logic [31:0]       rd_mux;
  // boundary decisions
  logic              step_fire;
  logic              int_fire;
  // datapath results
  logic [DATA_W-1:0] c_result;
  logic              c_sign;
  logic              c_zero;
  logic              c_aux;
  logic              c_parity;
  logic              c_carry;

  // shared adder and flag logic
  psf_flag_calc #(
    .W (DATA_W)
  ) u_calc (
    .op_a_i   (ALU_OP_A_I),
    .op_b_i   (ALU_OP_B_I),
    .sub_i    (ALU_SUB_I),
    .result_o (c_result),
    .sign_o   (c_sign),
    .zero_o   (c_zero),
    .aux_o    (c_aux),
    .parity_o (c_parity),
    .carry_o  (c_carry)
  );

  // apb phase decode; the access phase always lasts exactly one cycle
  assign setup    = PSEL_I & ~PENABLE_I;
  assign access   = PSEL_I & PENABLE_I & PREADY_O;
  assign mapped   = (PADDR_I == psf_pkg::OFS_FLAGS) | (PADDR_I == psf_pkg::OFS_STATUS) |
                    (PADDR_I == psf_pkg::OFS_INT_EN) | (PADDR_I == psf_pkg::OFS_INT_CLR);
  assign wr_flags = access & PWRITE_I & (PADDR_I == psf_pkg::OFS_FLAGS);
  assign wr_en    = access & PWRITE_I & (PADDR_I == psf_pkg::OFS_INT_EN) & PSTRB_I[0];
  assign wr_clr   = access & PWRITE_I & (PADDR_I == psf_pkg::OFS_INT_CLR) & PSTRB_I[0];

  // reserved positions are constants, never flip-flops
  always_comb begin
    flags_view                    = psf_pkg::FLAGS_RESET & ~psf_pkg::FLAGS_WR_MASK;
    flags_view[psf_pkg::BIT_RSV1] = 1'b1;
    flags_view[psf_pkg::BIT_RSV3] = 1'b0;
    flags_view[psf_pkg::BIT_RSV5] = 1'b0;
    flags_view[psf_pkg::BIT_CARRY]  = carry_q;
    flags_view[psf_pkg::BIT_PARITY] = parity_q;
    flags_view[psf_pkg::BIT_AUX]    = aux_q;
    flags_view[psf_pkg::BIT_ZERO]   = zero_q;
    flags_view[psf_pkg::BIT_SIGN]   = sign_q;
    flags_view[psf_pkg::BIT_TRAP]   = trap_q;
    flags_view[psf_pkg::BIT_IF]   = if_q;
  end

  // read mux; write-only clear register reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      psf_pkg::OFS_FLAGS:  rd_mux = flags_view;
      psf_pkg::OFS_STATUS: rd_mux = {30'h0000_0000, status_q};
      psf_pkg::OFS_INT_EN: rd_mux = {30'h0000_0000, int_en_q};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: data and error latched in setup, pready high in the access cycle
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup;
      PRDATA_O  <= (setup & ~PWRITE_I) ? rd_mux : 32'h0000_0000;
      PSLVERR_O <= setup & ~mapped;
    end
  end

  // trap outranks an external request at the same boundary
  assign step_fire = INSN_DONE_I & trap_q;
  assign int_fire  = INSN_DONE_I & if_q & MASKABLE_INTERRUPT_REQUEST_I & ~trap_q;

  // boundary outputs are one-cycle pulses
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      INT_ACCEPT_O <= 1'b0;
      STEP_TRAP_O  <= 1'b0;
    end else begin
      INT_ACCEPT_O <= int_fire;
      STEP_TRAP_O  <= step_fire;
    end
  end

  // control flags; a write in the trap cycle wins so software keeps the last word
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      if_q <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_IF];
      trap_q <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_TRAP];
    end else if (wr_flags && PSTRB_I[1]) begin
      if_q   <= PWDATA_I[psf_pkg::BIT_IF];
      trap_q <= PWDATA_I[psf_pkg::BIT_TRAP];
    end else if (step_fire) begin
      trap_q <= 1'b0;
    end
  end

  // arithmetic flags; a software write takes priority over a datapath update
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      sign_q   <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_SIGN];
      zero_q   <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_ZERO];
      aux_q    <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_AUX];
      parity_q <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_PARITY];
      carry_q  <= psf_pkg::FLAGS_RESET[psf_pkg::BIT_CARRY];
    end else if (wr_flags && PSTRB_I[0]) begin
      sign_q   <= PWDATA_I[psf_pkg::BIT_SIGN];
      zero_q   <= PWDATA_I[psf_pkg::BIT_ZERO];
      aux_q    <= PWDATA_I[psf_pkg::BIT_AUX];
      parity_q <= PWDATA_I[psf_pkg::BIT_PARITY];
      carry_q  <= PWDATA_I[psf_pkg::BIT_CARRY];
    end else if (ALU_VALID_I) begin
      sign_q   <= c_sign;
      zero_q   <= c_zero;
      aux_q    <= c_aux;
      parity_q <= c_parity;
      carry_q  <= c_carry;
    end
  end

  // result register for the datapath
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      ALU_RESULT_O <= '0;
    end else if (ALU_VALID_I) begin
      ALU_RESULT_O <= c_result;
    end
  end

  // registered flag view keeps the output straight from a flop
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      FLAGS_O <= psf_pkg::FLAGS_RESET;
    end else begin
      FLAGS_O <= flags_view;
    end
  end

  // sticky events: a set in the clear cycle survives
  assign ev_set[psf_pkg::EV_INT]  = int_fire;
  assign ev_set[psf_pkg::EV_STEP] = step_fire;
  assign ev_clr = wr_clr ? PWDATA_I[psf_pkg::EV_W-1:0] : 2'h0;

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      status_q <= psf_pkg::EV_RESET;
    end else begin
      status_q <= (status_q & ~ev_clr) | ev_set;
    end
  end

  // interrupt enable mask
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      int_en_q <= psf_pkg::EV_RESET;
    end else if (wr_en) begin
      int_en_q <= PWDATA_I[psf_pkg::EV_W-1:0];
    end
  end

  // level interrupt; one cycle behind the status bit
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status_q & int_en_q);
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  // request at a boundary with the trap flag clear is accepted exactly when the interrupt flag was set
  property p_int_gate;
    (INSN_DONE_I && MASKABLE_INTERRUPT_REQUEST_I && !trap_q) |=> (INT_ACCEPT_O == $past(if_q));
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt acceptance ignores flag");

  // completion with the trap flag set raises the trap one cycle later
  property p_step_raise;
    (INSN_DONE_I && trap_q) |=> STEP_TRAP_O && !INT_ACCEPT_O;
  endproperty
  a_step_raise: assert property (p_step_raise) else $error("single-step trap missing");

  // trap taken without a competing write leaves the trap flag clear
  property p_step_clear;
    (INSN_DONE_I && trap_q && !wr_flags) |=> !trap_q ##1 !FLAGS_O[psf_pkg::BIT_TRAP];
  endproperty
  a_step_clear: assert property (p_step_clear) else $error("trap flag not cleared");

  // sign follows the top bit of the registered sum or difference
  property p_sign;
    (ALU_VALID_I && !wr_flags) |=> sign_q == ALU_RESULT_O[DATA_W-1];
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

  // zero flag against the registered result
  property p_zero;
    (ALU_VALID_I && !wr_flags) |=> zero_q == (ALU_RESULT_O == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // nibble carry computed independently from the low nibbles
  property p_aux;
    (ALU_VALID_I && !wr_flags) |=> aux_q == $past(ALU_SUB_I ? (ALU_OP_A_I[3:0] < ALU_OP_B_I[3:0])
                                                  : ({1'b0, ALU_OP_A_I[3:0]} + {1'b0, ALU_OP_B_I[3:0]} > 5'h0F));
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary carry wrong");

  // parity against the registered result, visible on the flag view next cycle
  property p_parity;
    (ALU_VALID_I && !wr_flags) |=> parity_q == ~^ALU_RESULT_O[7:0] ##1 FLAGS_O[psf_pkg::BIT_PARITY] == $past(parity_q);
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  // carry against a magnitude compare for subtraction and overflow for addition
  property p_carry;
    (ALU_VALID_I && !wr_flags) |=> carry_q == $past(ALU_SUB_I ? (ALU_OP_A_I < ALU_OP_B_I)
                                                  : (ALU_OP_A_I > ~ALU_OP_B_I));
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  // reserved zeros 3 and 5 hold on the output, bits 31 to 10 on reads
  property p_rsv_zero;
    !FLAGS_O[psf_pkg::BIT_RSV3] && !FLAGS_O[psf_pkg::BIT_RSV5] && (PRDATA_O[31:10] == 22'h000000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved zero bit set");

  // reserved one survives a write of zeros
  property p_rsv_one;
    wr_flags |=> ##1 FLAGS_O[psf_pkg::BIT_RSV1];
  endproperty
  a_rsv_one: assert property (p_rsv_one) else $error("reserved one bit lost");

  // a full flag write lands on every defined bit two cycles on; a later update cannot reach the view yet
  property p_write;
    (wr_flags && PSTRB_I[1:0] == 2'h3) |=> ##1
      ((FLAGS_O & psf_pkg::FLAGS_WR_MASK) == ($past(PWDATA_I, 2) & psf_pkg::FLAGS_WR_MASK));
  endproperty
  a_write: assert property (p_write) else $error("flag write mismatch");

endmodule

/* core/psf_pkg.sv */
// constants shared by the processor status flag block
package psf_pkg;

  // register byte offsets on the apb slave
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] OFS_FLAGS   = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_INT_EN  = 12'h008;
  localparam logic [11:0] OFS_INT_CLR = 12'h00C;

  // bit positions inside processor_flags
  localparam int unsigned BIT_CARRY  = 0;
  localparam int unsigned BIT_RSV1   = 1;
  localparam int unsigned BIT_PARITY = 2;
  localparam int unsigned BIT_RSV3   = 3;
  localparam int unsigned BIT_AUX    = 4;
  localparam int unsigned BIT_RSV5   = 5;
  localparam int unsigned BIT_ZERO   = 6;
  localparam int unsigned BIT_SIGN   = 7;
  localparam int unsigned BIT_TRAP   = 8;
  localparam int unsigned BIT_IF     = 9;

  // reset value, writable bits and the fixed-one bit of processor_flags
  localparam logic [31:0] FLAGS_RESET     = 32'h0000_0002;
  localparam logic [31:0] FLAGS_WR_MASK   = 32'h0000_03D5;
  localparam logic [31:0] FLAGS_FIXED_ONE = 32'h0000_0002;

  // event bits shared by status, enable and clear registers
  localparam int unsigned EV_INT  = 0;
  localparam int unsigned EV_STEP = 1;
  localparam int unsigned EV_W    = 2;
  localparam logic [1:0]  EV_RESET = 2'h0;

  // nibble boundary watched by the auxiliary carry
  localparam int unsigned AUX_BIT = 4;

endpackage

/* core/psf_flag_calc.sv */
// adder/subtractor and arithmetic flag generation for the status flag block
`timescale 1ns/1ps
module psf_flag_calc #(
  parameter int unsigned W = 32
) (
  // operands
  input  wire logic [W-1:0] op_a_i,
  input  wire logic [W-1:0] op_b_i,
  input  wire logic         sub_i,
  // result and flags
  output logic      [W-1:0] result_o,
  output logic              sign_o,
  output logic              zero_o,
  output logic              aux_o,
  output logic              parity_o,
  output logic              carry_o
);

  logic [W:0] wide;

  // one adder serves both ops; subtraction adds the inverted operand plus one
  always_comb begin
    if (sub_i) begin
      wide = {1'b0, op_a_i} + {1'b0, ~op_b_i} + {{W{1'b0}}, 1'b1};
    end else begin
      wide = {1'b0, op_a_i} + {1'b0, op_b_i};
    end
  end

  assign result_o = wide[W-1:0];

  // sign is the top result bit
  assign sign_o = wide[W-1];
  assign zero_o = (wide[W-1:0] == '0);
  // carry into bit 4 is both add carry and subtract borrow, operands xor result
  assign aux_o = op_a_i[psf_pkg::AUX_BIT] ^ op_b_i[psf_pkg::AUX_BIT] ^ wide[psf_pkg::AUX_BIT];
  // even count of ones in the low byte
  assign parity_o = ~^wide[7:0];
  // inverted adder carry is the borrow when subtracting
  assign carry_o = wide[W] ^ sub_i;

endmodule

/* tb/psf_exec_model.sv */
// behavioural model of the execution datapath and instruction boundary logic
`timescale 1ns/1ps
module psf_exec_model (
  // clock
  input  wire logic        clk_i,
  // datapath and boundary drive
  output logic             alu_valid_o,
  output logic             alu_sub_o,
  output logic [31:0]      op_a_o,
  output logic [31:0]      op_b_o,
  output logic             insn_done_o,
  output logic             irq_req_o
);
  // quiet at time zero so nothing is taken while reset is applied
  initial begin
    alu_valid_o = 1'b0;
    alu_sub_o   = 1'b0;
    op_a_o      = 32'h0000_0000;
    op_b_o      = 32'h0000_0000;
    insn_done_o = 1'b0;
    irq_req_o   = 1'b0;
  end

  // one operation for one cycle; operands inverted afterwards so stale data never looks valid
  task automatic alu_op(input logic [31:0] a, input logic [31:0] b, input logic sub);
    @(posedge clk_i);
    alu_valid_o <= 1'b1;
    alu_sub_o   <= sub;
    op_a_o      <= a;
    op_b_o      <= b;
    @(posedge clk_i);
    alu_valid_o <= 1'b0;
    op_a_o      <= ~a;
    op_b_o      <= ~b;
  endtask

  // one-cycle instruction boundary pulse
  task automatic boundary();
    @(posedge clk_i);
    insn_done_o <= 1'b1;
    @(posedge clk_i);
    insn_done_o <= 1'b0;
  endtask

  // level request from the interrupt source
  task automatic set_req(input logic r);
    @(posedge clk_i);
    irq_req_o <= r;
  endtask
endmodule

/* tb/psf_top_tb.sv */
// self-checking testbench for the processor status flag block
`timescale 1ns/1ps
module psf_top_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, flags, result, a, b;
  logic        pready, pslverr, valid, sub, done, req, accept, trap, irq, err;
  int          mismatches = 0;
  int          checked = 0;
  int          seed = 65;

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  psf_top DUT (.MCLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ALU_VALID_I(valid), .ALU_SUB_I(sub), .ALU_OP_A_I(a), .ALU_OP_B_I(b),
    .ALU_RESULT_O(result), .INSN_DONE_I(done), .MASKABLE_INTERRUPT_REQUEST_I(req),
    .INT_ACCEPT_O(accept), .STEP_TRAP_O(trap), .FLAGS_O(flags), .IRQ_O(irq));

  psf_exec_model u_exec (.clk_i(clk), .alu_valid_o(valid), .alu_sub_o(sub), .op_a_o(a), .op_b_o(b),
    .insn_done_o(done), .irq_req_o(req));

  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // apb transfer: request held until pready is sampled high; only the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, ad, 32'h0000_0000, d);
    chk(what, exp, d);
  endtask

  // flag view expected after an add or subtract, control bits assumed clear
  function automatic logic [31:0] exp_flags(input logic [31:0] x, input logic [31:0] y, input logic s);
    logic [32:0] r;
    logic        af;
    r  = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    af = s ? (x[3:0] < y[3:0]) : ({1'b0, x[3:0]} + {1'b0, y[3:0]} > 5'h0F);
    return 32'h0000_0002 | {24'h0, r[31], r[31:0] == 32'h0, 1'b0, af, 1'b0, ~^r[7:0], 1'b0, r[32]};
  endfunction

  // one operation, result then flag view one edge after the operands are taken
  task automatic alu_chk(input logic [31:0] x, input logic [31:0] y, input logic s);
    u_exec.alu_op(x, y, s);
    @(posedge clk);
    #1;
    chk("result", s ? x - y : x + y, result);
    chk("flags", exp_flags(x, y, s), flags);
  endtask

  // hang guard of 20000 cycles, far above the some two hundred cycles of traffic
  initial begin
    #500000;
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("reset flags", 32'h0000_0002, flags);
    rd_chk("flags reg", 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF, d);
    rd_chk("all ones", 12'h000, 32'h0000_03D7);
    apb(1'b1, 12'h000, 32'h0000_0000, d);
    rd_chk("all zero", 12'h000, 32'h0000_0002);
    // low lane only: arithmetic flags take the word, control flags stay clear
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'hFFFF_FFFF, d);
    pstrb <= 4'hF;
    rd_chk("lane0 only", 12'h000, 32'h0000_00D7);
    apb(1'b0, 12'h010, 32'h0000_0000, d);
    chk("unmapped err", 32'h1, {31'h0, err});
    // corners: zero, wrap to zero, borrow, nibble carry and borrow, sign
    alu_chk(32'h0000_0000, 32'h0000_0000, 1'b0);
    alu_chk(32'hFFFF_FFFF, 32'h0000_0001, 1'b0);
    alu_chk(32'h0000_0000, 32'h0000_0001, 1'b1);
    alu_chk(32'h0000_0008, 32'h0000_0008, 1'b0);
    alu_chk(32'h0000_0010, 32'h0000_0001, 1'b1);
    alu_chk(32'h7FFF_FFFF, 32'h0000_0001, 1'b0);
    repeat (40) alu_chk($random(seed), $random(seed), $random(seed));
    // masked then accepted maskable request
    u_exec.set_req(1'b1);
    apb(1'b1, 12'h000, 32'h0000_0000, d);
    u_exec.boundary();
    #1;
    chk("masked accept", 32'h0, {31'h0, accept});
    apb(1'b1, 12'h000, 32'h0000_0200, d);
    u_exec.boundary();
    #1;
    chk("accept", 32'h1, {31'h0, accept});
    u_exec.set_req(1'b0);
    chk("irq disabled", 32'h0, {31'h0, irq});
    rd_chk("status", 12'h004, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_0003, d);
    @(posedge clk);
    #1;
    chk("irq enabled", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00C, 32'h0000_0003, d);
    rd_chk("status cleared", 12'h004, 32'h0000_0000);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // single step trap taken and trap flag dropped
    apb(1'b1, 12'h000, 32'h0000_0100, d);
    u_exec.boundary();
    #1;
    chk("step trap", 32'h1, {31'h0, trap});
    @(posedge clk);
    #1;
    chk("trap flag", 32'h0, {31'h0, flags[8]});
    chk("irq trap", 32'h1, {31'h0, irq});
    rd_chk("status trap", 12'h004, 32'h0000_0002);
    wrap_up();
  end
endmodule
